// [dual_tap_chain.sv]
`timescale 1ns/1ps
// Contract
// R1: fast clock bit reads 1 when write clock wins evaluation, 0 when read wins.
// R2: software write to the bit overrides the evaluated fast clock choice; a write made before evaluation ends is replaced by its result.
// R3: after the bit changes, outside party waits the settling time.
// R4: inputs sampled on rising test clock, outputs change on falling; pad_out and pad_oe follow ir2 and bsr_upd, which load on the rising clock.
// R5: mode select and data in pulled high; idle port stays in reset.
// R6: serial data enters register MSB and leaves from LSB.
// R7: data out driven only in shift states.
// R8: five rising clocks with mode select high reach reset.
// R9: current instruction selects exactly one data register.
// R10: two ports in series, 3-bit and 8-bit instruction, one bypass bit each.
// R11: reset state loads the identification instruction.
// R12: bypass register is one flip-flop.
// R13: both ports in bypass give two clock delay in to out.
// R14: each instruction load carries bypass for port one plus port two code.
// R15: port two decodes bypass, extest, highz, sample, idcode; port one bypass.
// R16: boundary register captures pins at capture, shifts at shift.
// R17: idcode loads fixed 32-bit code at capture and shifts it out.
// R18: sample snapshots pins; shift in and out happen together.
// R19: preload leaves shifted pattern in boundary update latches.
// R20: highz floats user pins and selects bypass.
// R21: extest drives preloaded values and shifts boundary register.
// R22: controller has 16 states stepped by mode select on rising clock.
// R23: fast clock bit is bit 7 of configuration register 0xa.
// R24: settling wait lasts up to 1024 cycles.
// R25: controller follows standard graph; instructions apply in update state.
module dual_tap_chain
    import scan_pkg::*;
#(
    parameter logic [31:0] ID_CODE = 32'h0a5a_5001 // arbitrary value
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // test port pins
    input scan_pkg::scan_in_type scan_in,
    output scan_pkg::scan_out_type scan_out,
    // core side of user pins
    input wire logic [7:0] core_out,
    input wire logic [7:0] core_oe,
    // pad side of user pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    // fifo clocks
    input wire logic wr_clk,
    input wire logic rd_clk,
    // configuration register access
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic fclk_settling
);
    import scan_pkg::*;

    typedef struct packed {
        logic tck_m;
        logic tck_s;
        logic tck_d;
        logic tms_m;
        logic tms_s;
        logic tdi_m;
        logic tdi_s;
        logic [PIN_NUM-1:0] pin_m;
        logic [PIN_NUM-1:0] pin_s;
        logic [IR1_LEN-1:0] ir1_sh;
        logic [IR1_LEN-1:0] ir1;
        logic [IR2_LEN-1:0] ir2_sh;
        logic [IR2_LEN-1:0] ir2;
        logic byp1;
        logic byp2;
        logic [ID_LEN-1:0] id_sh;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_upd;
        logic tdo;
        logic tdo_oe;
        logic [PIN_NUM-1:0] pad_out;
        logic [PIN_NUM-1:0] pad_oe;
    } chain_state_type;

    chain_state_type s_reg;
    chain_state_type s_next;
    tap_state_type state;
    logic tck_rise;
    logic tck_fall;
    logic sel_id;
    logic sel_bsr;
    logic is_extest;
    logic is_highz;
    logic p2_out;
    logic fast_clk;
    logic ovr_wr;

    // ==========================================================
    // test clock edges found from the synchronised pin
    assign tck_rise = s_reg.tck_s & ~s_reg.tck_d; // [R4]
    assign tck_fall = ~s_reg.tck_s & s_reg.tck_d; // [R4]

    // ==========================================================
    // shared controller, both ports see the same mode select
    tap_ctrl u_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .tck_rise(tck_rise),
        .tms(s_reg.tms_s),
        .state(state)
    );

    // ==========================================================
    // fast clock choice and its override
    assign ovr_wr = cfg_wr && (cfg_addr == FCLK_CFG_ADDR); // [R23]

    fast_clk_sel u_fclk (
        .clk(clk),
        .rst_n(rst_n),
        .wr_clk(wr_clk),
        .rd_clk(rd_clk),
        .ovr_wr(ovr_wr),
        .ovr_val(cfg_wdata[FCLK_BIT_POS]),
        .fast_clk(fast_clk),
        .settling(fclk_settling)
    );

    // reads of the fast clock register, other bits zero
    always_comb begin
        cfg_rdata = 8'h00;
        if (cfg_addr == FCLK_CFG_ADDR) begin
            cfg_rdata[FCLK_BIT_POS] = fast_clk; // [R1] [R23]
        end
    end

    // ==========================================================
    // port two instruction decode
    always_comb begin
        sel_id = 1'b0;
        sel_bsr = 1'b0;
        is_extest = 1'b0;
        is_highz = 1'b0;
        case (s_reg.ir2) // [R15] [R9]
            IR2_IDCODE: sel_id = 1'b1;
            IR2_SAMPLE: sel_bsr = 1'b1;
            IR2_EXTEST: begin
                sel_bsr = 1'b1;
                is_extest = 1'b1;
            end
            IR2_HIGHZ: is_highz = 1'b1; // [R20]
            default: sel_id = 1'b0; // bypass and unknown codes
        endcase
    end

    // lsb of the register that port two places in the chain
    always_comb begin
        if (sel_id) begin
            p2_out = s_reg.id_sh[0];
        end else if (sel_bsr) begin
            p2_out = s_reg.bsr_sh[0];
        end else begin
            p2_out = s_reg.byp2; // [R12]
        end
    end

    // ==========================================================
    // next state of the chain
    always_comb begin
        s_next = s_reg;
        // two-stage synchronisers, test pins reset high as if pulled up, user pins reset low
        s_next.tck_m = scan_in.tck;
        s_next.tck_s = s_reg.tck_m;
        s_next.tck_d = s_reg.tck_s;
        s_next.tms_m = scan_in.tms;
        s_next.tms_s = s_reg.tms_m;
        s_next.tdi_m = scan_in.tdi;
        s_next.tdi_s = s_reg.tdi_m;
        s_next.pin_m = pin_in;
        s_next.pin_s = s_reg.pin_m;
        if (tck_rise) begin // [R4]
            case (state)
                ST_RESET: begin
                    s_next.ir2 = IR2_IDCODE; // [R11]
                    s_next.ir1 = IR1_RESET;
                end
                ST_CAP_IR: begin
                    s_next.ir2_sh = IR2_CAPTURE;
                    s_next.ir1_sh = IR1_CAPTURE;
                end
                ST_SHIFT_IR: begin
                    // port two sits nearer the data input [R10] [R14]
                    s_next.ir2_sh = {s_reg.tdi_s, s_reg.ir2_sh[IR2_LEN-1:1]}; // [R6]
                    s_next.ir1_sh = {s_reg.ir2_sh[0], s_reg.ir1_sh[IR1_LEN-1:1]};
                end
                ST_UPD_IR: begin
                    s_next.ir2 = s_reg.ir2_sh; // [R25]
                    s_next.ir1 = s_reg.ir1_sh;
                end
                ST_CAP_DR: begin
                    s_next.byp1 = 1'b0;
                    s_next.byp2 = 1'b0;
                    if (sel_id) s_next.id_sh = ID_CODE; // [R17]
                    if (sel_bsr) s_next.bsr_sh = {core_out, s_reg.pin_s}; // [R16] [R18]
                end
                ST_SHIFT_DR: begin
                    // port one decodes bypass only
                    s_next.byp1 = p2_out; // [R13] [R12]
                    if (sel_id) begin
                        s_next.id_sh = {s_reg.tdi_s, s_reg.id_sh[ID_LEN-1:1]}; // [R6] [R17]
                    end else if (sel_bsr) begin
                        s_next.bsr_sh = {s_reg.tdi_s, s_reg.bsr_sh[BSR_LEN-1:1]}; // [R18]
                    end else begin
                        s_next.byp2 = s_reg.tdi_s; // [R12] [R20]
                    end
                end
                ST_UPD_DR: begin
                    if (sel_bsr) s_next.bsr_upd = s_reg.bsr_sh; // [R19]
                end
                default: s_next.byp1 = s_reg.byp1;
            endcase
        end
        // data out changes only on the falling test clock
        if (tck_fall) begin // [R4]
            s_next.tdo_oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR); // [R7]
            s_next.tdo = (state == ST_SHIFT_IR) ? s_reg.ir1_sh[0] : s_reg.byp1;
        end
        // user pin drive follows the active instruction
        if (is_highz) begin
            s_next.pad_out = core_out;
            s_next.pad_oe = '0; // [R20]
        end else if (is_extest) begin
            s_next.pad_out = s_reg.bsr_upd[BSR_LEN-1:PIN_NUM]; // [R21]
            s_next.pad_oe = '1;
        end else begin
            s_next.pad_out = core_out;
            s_next.pad_oe = core_oe;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.tck_m <= 1'b1;
            s_reg.tck_s <= 1'b1;
            s_reg.tck_d <= 1'b1;
            s_reg.tms_m <= 1'b1; // [R5]
            s_reg.tms_s <= 1'b1;
            s_reg.tdi_m <= 1'b1; // [R5]
            s_reg.tdi_s <= 1'b1;
            s_reg.ir1 <= IR1_RESET;
            s_reg.ir2 <= IR2_IDCODE; // [R11]
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs
    assign scan_out.tdo = s_reg.tdo;
    assign scan_out.tdo_oe = s_reg.tdo_oe;
    assign pad_out = s_reg.pad_out;
    assign pad_oe = s_reg.pad_oe;

endmodule // dual_tap_chain

// [scan_pkg.sv]
package scan_pkg;

    // ==========================================================
    // chain geometry
    localparam int IR1_LEN = 3;
    localparam int IR2_LEN = 8;
    localparam int PIN_NUM = 8;
    localparam int BSR_LEN = 16;
    localparam int ID_LEN = 32;

    // ==========================================================
    // instruction codes and reset values
    localparam logic [2:0] IR1_BYPASS = 3'h7;
    localparam logic [2:0] IR1_RESET = 3'h7;
    localparam logic [2:0] IR1_CAPTURE = 3'h1;
    localparam logic [7:0] IR2_BYPASS = 8'hff;
    localparam logic [7:0] IR2_EXTEST = 8'h00;
    localparam logic [7:0] IR2_HIGHZ = 8'h07;
    localparam logic [7:0] IR2_SAMPLE = 8'h01;
    localparam logic [7:0] IR2_IDCODE = 8'h0f;
    localparam logic [7:0] IR2_CAPTURE = 8'h01;

    // ==========================================================
    // fast clock configuration bit
    localparam logic [3:0] FCLK_CFG_ADDR = 4'ha;
    localparam int FCLK_BIT_POS = 7;
    localparam logic FCLK_RESET = 1'b1;
    localparam logic [8:0] CLK_EVAL_TERM = 9'h100;
    localparam int SETTLE_CYCLES = 1024;
    localparam logic [10:0] SETTLE_CNT = 11'(SETTLE_CYCLES);

    // ==========================================================
    // controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_type;

    // ==========================================================
    // pin bundles
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_in_type;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } scan_out_type;

endpackage

// [tap_ctrl.sv]
`timescale 1ns/1ps
module tap_ctrl
    import scan_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sampled test inputs
    input wire logic tck_rise,
    input wire logic tms,
    // controller state
    output scan_pkg::tap_state_type state
);
    import scan_pkg::*;

    typedef struct packed {
        tap_state_type st;
    } ctrl_state_type;

    ctrl_state_type s_reg;
    ctrl_state_type s_next;

    // ==========================================================
    // state graph, advanced on each rising test clock
    always_comb begin
        s_next = s_reg;
        if (tck_rise) begin // [R22]
            case (s_reg.st)
                ST_RESET: s_next.st = tms ? ST_RESET : ST_IDLE;
                ST_IDLE: s_next.st = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: s_next.st = tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: s_next.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: s_next.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: s_next.st = tms ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: s_next.st = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: s_next.st = tms ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR: s_next.st = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: s_next.st = tms ? ST_RESET : ST_CAP_IR; // [R8]
                ST_CAP_IR: s_next.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: s_next.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: s_next.st = tms ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: s_next.st = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: s_next.st = tms ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR: s_next.st = tms ? ST_SEL_DR : ST_IDLE; // [R25]
                default: s_next.st = ST_RESET;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.st <= ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign state = s_reg.st;

endmodule // tap_ctrl

// [fast_clk_sel.sv]
`timescale 1ns/1ps
module fast_clk_sel
    import scan_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fifo clocks from pins
    input wire logic wr_clk,
    input wire logic rd_clk,
    // software override
    input wire logic ovr_wr,
    input wire logic ovr_val,
    // result
    output logic fast_clk,
    output logic settling
);
    import scan_pkg::*;

    typedef struct packed {
        logic wr_m;
        logic wr_s;
        logic wr_d;
        logic rd_m;
        logic rd_s;
        logic rd_d;
        logic [8:0] wr_cnt;
        logic [8:0] rd_cnt;
        logic done;
        logic fast;
        logic [10:0] settle;
    } fclk_state_type;

    fclk_state_type s_reg;
    fclk_state_type s_next;
    logic wr_rise;
    logic rd_rise;
    logic new_fast;

    // ==========================================================
    // evaluation counters, override and settling wait
    always_comb begin
        s_next = s_reg;
        s_next.wr_m = wr_clk;
        s_next.wr_s = s_reg.wr_m;
        s_next.wr_d = s_reg.wr_s;
        s_next.rd_m = rd_clk;
        s_next.rd_s = s_reg.rd_m;
        s_next.rd_d = s_reg.rd_s;
        wr_rise = s_reg.wr_s & ~s_reg.wr_d;
        rd_rise = s_reg.rd_s & ~s_reg.rd_d;
        new_fast = s_reg.fast;
        if (!s_reg.done) begin
            if (wr_rise) s_next.wr_cnt = s_reg.wr_cnt + 9'h001;
            if (rd_rise) s_next.rd_cnt = s_reg.rd_cnt + 9'h001;
            // first counter to terminal count names the faster clock
            if (s_next.wr_cnt == CLK_EVAL_TERM) begin // [R1]
                s_next.done = 1'b1;
                new_fast = 1'b1;
            end else if (s_next.rd_cnt == CLK_EVAL_TERM) begin
                s_next.done = 1'b1;
                new_fast = 1'b0;
            end
        end
        if (ovr_wr) begin // [R2]
            new_fast = ovr_val;
        end
        s_next.fast = new_fast;
        // restart the settling wait on any change
        if (new_fast != s_reg.fast) begin
            s_next.settle = SETTLE_CNT; // [R24]
        end else if (s_reg.settle != 11'h000) begin
            s_next.settle = s_reg.settle - 11'h001;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.fast <= FCLK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign fast_clk = s_reg.fast;
    assign settling = (s_reg.settle != 11'h000); // [R3]

endmodule // fast_clk_sel

// [chain_sva.sv]
`timescale 1ns/1ps
module chain_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins
    input scan_pkg::scan_in_type scan_in,
    input scan_pkg::scan_out_type scan_out,
    // configuration access
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic fclk_settling
);
    import scan_pkg::*;

    typedef struct packed {
        logic [10:0] hi_cnt;
    } sva_state_type;

    sva_state_type st_reg;
    sva_state_type st_next;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // helper logic
    // length of the current settling run
    always_comb begin
        st_next = st_reg;
        st_next.hi_cnt = fclk_settling ? st_reg.hi_cnt + 11'h001 : 11'h000;
    end

    // register the helper state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // link timing
    chk_tdo_edge: assert property (
        $changed(scan_out.tdo) |-> !$past(scan_in.tck, 2) && !$past(scan_in.tck, 3)
    ) else $error("tdo changed outside a test clock low phase");

    chk_oe_edge: assert property (
        $changed(scan_out.tdo_oe) |-> !$past(scan_in.tck, 2) && !$past(scan_in.tck, 3)
    ) else $error("tdo enable changed outside a test clock low phase");

    // ==========================================================
    // fast clock bit and settling wait
    chk_settle_max: assert property (
        fclk_settling |-> st_reg.hi_cnt < 11'h400
    ) else $error("settling lasted too long");

    chk_settle_full: assert property (
        $fell(fclk_settling) |-> st_reg.hi_cnt == 11'h400
    ) else $error("settling ended early");

    chk_settle_hold: assert property (
        $rose(fclk_settling) |-> fclk_settling [*8]
    ) else $error("settling pulse too short");

    chk_settle_start: assert property (
        cfg_wr && cfg_addr == FCLK_CFG_ADDR && cfg_wdata[7] != cfg_rdata[7] |=> fclk_settling
    ) else $error("bit change did not start settling");

    chk_cfg_write: assert property (
        cfg_wr && cfg_addr == FCLK_CFG_ADDR
        |=> cfg_addr != FCLK_CFG_ADDR || cfg_rdata[7] == $past(cfg_wdata[7])
    ) else $error("written fast clock value not taken");

    chk_rdata_other: assert property (
        cfg_addr != FCLK_CFG_ADDR |-> cfg_rdata == 8'h00
    ) else $error("read of other address not zero");

    // main scenarios
    cover property ($rose(scan_out.tdo_oe));
    cover property ($rose(fclk_settling));
    cover property (cfg_wr && cfg_addr != FCLK_CFG_ADDR);
endmodule // chain_sva

// [scan_host.sv]
`timescale 1ns/1ps
module scan_host (
    // link pins
    output scan_pkg::scan_in_type scan_in,
    input scan_pkg::scan_out_type scan_out
);
    import scan_pkg::*;

    // link clock stands low, released lines read as pulled high
    initial begin
        scan_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    end

    // one 200 ns link clock, tdo taken in the high phase
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v,
                        output logic oe_v);
        scan_in.tms = tms_v;
        scan_in.tdi = tdi_v;
        #100;
        scan_in.tck = 1'b1;
        #50;
        tdo_v = scan_out.tdo;
        oe_v = scan_out.tdo_oe;
        #50;
        scan_in.tck = 1'b0;
        scan_in.tms = 1'b1;
        scan_in.tdi = 1'b1;
    endtask
endmodule // scan_host

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import scan_pkg::*;

    localparam logic [31:0] TB_ID = 32'h5c3a_0e71; // arbitrary value

    logic clk;
    logic rst_n;
    logic wr_clk;
    logic rd_clk;
    scan_in_type scan_in;
    scan_out_type scan_out;
    logic [7:0] core_out, core_oe, pin_in, pad_out, pad_oe, cfg_wdata, cfg_rdata;
    logic [3:0] cfg_addr;
    logic cfg_wr;
    logic fclk_settling;
    int num_errors = 0;
    int n_checks = 0;

    dual_tap_chain #(.ID_CODE(TB_ID)) dual_tap_chain_i (
        .clk(clk), .rst_n(rst_n), .scan_in(scan_in), .scan_out(scan_out),
        .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .wr_clk(wr_clk), .rd_clk(rd_clk), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .fclk_settling(fclk_settling)
    );

    scan_host scan_host_i (.scan_in(scan_in), .scan_out(scan_out));

    // ==========================================================
    // clocks: read clock faster than write clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        wr_clk = 1'b0;
        forever #75 wr_clk = ~wr_clk;
    end
    initial begin
        rd_clk = 1'b0;
        forever #50 rd_clk = ~rd_clk;
    end

    // ==========================================================
    // compare and closing tasks
    task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // link sequences
    // mode select bits sent lsb first
    task automatic tms_walk(input logic [7:0] seq, input int n);
        logic d, o;
        for (int i = 0; i < n; i++) begin
            scan_host_i.step(seq[i], 1'b1, d, o);
        end
    endtask

    // shift n bits from a shift state, then exit through update to idle
    task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        logic oe_all;
        oe_all = 1'b1;
        for (int j = 0; j < n; j++) begin
            scan_host_i.step(j == n - 1, din[j], dout[j], o);
            oe_all &= o;
        end
        tms_walk(8'h01, 2);
        cmp_bits(32'(oe_all), 32'h1);
        cmp_bits(32'(scan_out.tdo_oe), 32'h0);
    endtask

    task automatic load_ir(input logic [7:0] code);
        logic [63:0] q;
        tms_walk(8'h03, 4);
        shift(11, 64'({code, IR1_BYPASS}), q);
        cmp_bits(32'(q[10:0]), 32'({IR2_CAPTURE, IR1_CAPTURE}));
    endtask

    task automatic cfg_write(input logic [3:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_addr = 4'ha;
    endtask

    // ==========================================================
    // scenarios
    // from reset: one bypass bit then the id code
    task automatic check_id();
        logic [63:0] q;
        tms_walk(8'h02, 4);
        shift(33, 64'h0, q);
        cmp_bits(32'(q[0]), 32'h0);
        cmp_bits(q[32:1], TB_ID);
    endtask

    task automatic t_bypass();
        logic [63:0] q;
        logic [7:0] codes [3] = '{IR2_BYPASS, IR2_HIGHZ, 8'h5a};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            tms_walk(8'h01, 3);
            shift(10, 64'hc5, q);
            cmp_bits(32'(q[9:0]), 32'({8'hc5, 2'b00}));
            cmp_bits(32'(pad_oe), codes[i] == IR2_HIGHZ ? 32'h0 : 32'(core_oe));
        end
    endtask

    task automatic t_boundary();
        logic [63:0] q;
        load_ir(IR2_SAMPLE);
        cmp_bits(32'({pad_out, pad_oe}), 32'({core_out, core_oe}));
        tms_walk(8'h01, 3);
        shift(17, 64'({16'ha5c3, 1'b0}), q);
        cmp_bits(32'(q[16:0]), 32'({core_out, pin_in, 1'b0}));
        load_ir(IR2_EXTEST);
        repeat (2) @(negedge clk);
        cmp_bits(32'({pad_out, pad_oe}), 32'h0000_a5ff);
        tms_walk(8'h01, 3);
        shift(17, 64'h0, q);
        cmp_bits(32'(q[16:1]), 32'({core_out, pin_in}));
        cmp_bits(32'(pad_out), 32'h0);
    endtask

    // leave mid-scan by five rises with mode select high
    task automatic t_reset5();
        tms_walk(8'hf9, 8);
        check_id();
        cmp_bits(32'(pad_oe), 32'(core_oe));
    endtask

    task automatic t_config();
        int n;
        repeat (1800) @(negedge clk);
        cmp_bits(32'(cfg_rdata), 32'h0);
        cfg_write(4'h9, 8'h80);
        cmp_bits(32'({fclk_settling, cfg_rdata}), 32'h0);
        cfg_write(FCLK_CFG_ADDR, 8'h80);
        cmp_bits(32'(cfg_rdata), 32'h80);
        n = 0;
        while (fclk_settling === 1'b1 && n < 1100) begin
            n++;
            @(negedge clk);
        end
        cmp_bits(32'(n), 32'(SETTLE_CYCLES));
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        core_out = 8'h3c;
        core_oe = 8'h5a;
        pin_in = 8'h96;
        cfg_wr = 1'b0;
        cfg_addr = 4'ha;
        cfg_wdata = 8'h00;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        cmp_bits(32'(cfg_rdata), 32'({FCLK_RESET, 7'h00}));
        check_id();
        t_bypass();
        t_boundary();
        t_reset5();
        t_config();
        tally_and_finish();
    end

    // watchdog
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_top

bind dual_tap_chain chain_sva chain_sva_i (
    .clk(clk), .rst_n(rst_n), .scan_in(scan_in), .scan_out(scan_out), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .fclk_settling(fclk_settling)
);
